/* smd_partner.sv */
// Far-side model: bus receiver of the reports and the two motor contacts.
module smd_partner
	import smd_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire smd_pkg::smd_relay_s relay,
	input  wire logic                move_rpt_valid,
	input  wire logic                move_rpt_down,
	input  wire smd_pkg::smd_pos_s   pos_rpt
);
	import smd_pkg::*;
	int         n_move    = 0;
	logic       last_down = 1'b0;
	int         n_pos     = 0;
	logic [7:0] last_pos  = 8'h00;
	int         n_both    = 0;

	// A telegram is taken whenever its pulse is seen; the position is one unsigned byte.
	always @(posedge aclk) begin
		if (aresetn && move_rpt_valid) begin
			n_move++;
			last_down = move_rpt_down;
		end
		if (aresetn && pos_rpt.valid) begin
			n_pos++;
			last_pos = pos_rpt.pos;
		end
		if (relay.up && relay.down) begin
			n_both++;
		end
	end
endmodule : smd_partner

/* smd_pkg.sv */
// Package with constants, register map and carrier types of the shutter motor control.
package smd_pkg;

	// Clock rate and base time units.
	localparam int CLK_HZ           = 100_000_000;
	localparam int STEP_UNIT_MS     = 100;
	localparam int CYC_PER_UNIT     = CLK_HZ / 1000 * STEP_UNIT_MS;
	localparam int LONG_PRESS_MS    = 500;
	localparam int LONG_PRESS_UNITS = LONG_PRESS_MS / STEP_UNIT_MS;
	localparam int DEAD_MIN_UNITS   = 1;
	localparam int DEAD_MAX_UNITS   = 50;
	localparam int STEP_MIN         = 1;
	localparam int STEP_MAX         = 120;
	localparam int POS_FULL         = 100;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_TIMING = 8'h04;
	localparam logic [7:0] REG_CMD    = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;

	// Control register fields.
	localparam int CTRL_INV      = 0;
	localparam int CTRL_BLIND    = 1;
	localparam int CTRL_NIGHT    = 2;
	localparam int CTRL_KEYS     = 3;
	localparam int CTRL_POSEN    = 4;
	localparam int CTRL_FBEN     = 5;
	localparam int CTRL_RECOV_LO = 6;

	// Timing register fields: dead time units [7:0], step factor [15:8], travel seconds [31:16].
	localparam int TIM_DEAD_LO   = 0;
	localparam int TIM_STEP_LO   = 8;
	localparam int TIM_TRAVEL_LO = 16;

	// Command register: write strobes each command; value in [15:8].
	localparam int CMD_MOVE = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_STEP = 2;
	localparam int CMD_POS  = 3;
	localparam int CMD_VAL  = 8;

	localparam logic [31:0] CTRL_RST   = 32'h0000_0018;
	localparam logic [31:0] TIMING_RST = 32'h003C_0305;

	typedef enum logic [1:0] {
		SMD_RECOV_NONE = 2'b00,
		SMD_RECOV_UP   = 2'b01,
		SMD_RECOV_DOWN = 2'b10
	} smd_recov_e;

	typedef enum logic [2:0] {
		SMD_IDLE = 3'b000,
		SMD_RUN  = 3'b001,
		SMD_DEAD = 3'b010,
		SMD_STEP = 3'b011
	} smd_state_e;

	typedef struct packed {
		logic up;
		logic down;
	} smd_relay_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] pos;
	} smd_pos_s;

endpackage : smd_pkg

/* smd_top.sv */
// Shutter motor direction control with AXI4-Lite configuration registers.
module smd_top
	import smd_pkg::*;
#(
	parameter int UNIT_CYC = smd_pkg::CYC_PER_UNIT
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              bus_power,
	input  wire logic              key_up,
	input  wire logic              key_down,
	output smd_pkg::smd_relay_s    relay,
	output logic                   led_night,
	output logic                   led_move,
	output logic                   move_rpt_valid,
	output logic                   move_rpt_down,
	output smd_pkg::smd_pos_s      pos_rpt
);
	import smd_pkg::*;

	if (UNIT_CYC < 2) begin : g_unit_chk
		$error("UNIT_CYC must be at least 2");
	end

	// Register file and AXI4-Lite slave.
	logic [31:0] ctrl_ff;
	logic [31:0] timing_ff;
	logic        aw_ff;
	logic        w_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic        cmd_wr;
	logic [31:0] cmd_val;
	smd_state_e  state_ff;
	logic [7:0]  pos_ff;

	assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign s_axi_bresp   = 2'h0;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	logic        wr_go;
	logic [7:0]  wa;
	logic [31:0] wd;
	assign wa    = aw_ff ? awaddr_ff : s_axi_awaddr;
	assign wd    = w_ff ? wdata_ff : s_axi_wdata;
	assign wr_go = (aw_ff | (s_axi_awvalid & s_axi_awready))
		& (w_ff | (s_axi_wvalid & s_axi_wready));
	assign cmd_wr  = ce & wr_go & (wa == REG_CMD);
	assign cmd_val = wd;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff        <= 1'b0;
			w_ff         <= 1'b0;
			awaddr_ff    <= 8'h00;
			wdata_ff     <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else if (ce) begin
			if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_ff        <= 1'b0;
				w_ff         <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_ff     <= 1'b1;
					awaddr_ff <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_ff     <= 1'b1;
					wdata_ff <= s_axi_wdata;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff   <= CTRL_RST;
			timing_ff <= TIMING_RST;
		end else if (ce && wr_go) begin
			if (wa == REG_CTRL) ctrl_ff <= merge(ctrl_ff, wd, s_axi_wstrb);
			if (wa == REG_TIMING) timing_ff <= merge(timing_ff, wd, s_axi_wstrb);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (ce) begin
			if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				case (s_axi_araddr)
					REG_CTRL:   s_axi_rdata <= ctrl_ff;
					REG_TIMING: s_axi_rdata <= timing_ff;
					REG_CMD:    s_axi_rdata <= 32'h0000_0000;
					REG_STATUS: s_axi_rdata <= {19'h0_0000, state_ff, relay.down, relay.up,
						pos_ff};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end
		end
	end

	// Configuration fields.
	logic       inv;
	logic       blind;
	logic [1:0] recov;
	logic [7:0] dead_u;
	logic [7:0] step_n;
	logic [15:0] travel_s;
	assign inv      = ctrl_ff[CTRL_INV];
	assign blind    = ctrl_ff[CTRL_BLIND];
	assign recov    = ctrl_ff[CTRL_RECOV_LO +: 2];
	assign dead_u   = timing_ff[TIM_DEAD_LO +: 8];
	assign step_n   = timing_ff[TIM_STEP_LO +: 8];
	assign travel_s = timing_ff[TIM_TRAVEL_LO +: 16];

	// Pin synchronisers: change accepted when second and third stages agree.
	logic [2:0] pwr_sy;
	logic [2:0] ku_sy;
	logic [2:0] kd_sy;
	logic       pwr_ff;
	logic       ku_ff;
	logic       kd_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_sy <= 3'h0;
			ku_sy  <= 3'h0;
			kd_sy  <= 3'h0;
			pwr_ff <= 1'b0;
			ku_ff  <= 1'b0;
			kd_ff  <= 1'b0;
		end else if (ce) begin
			pwr_sy <= {pwr_sy[1:0], bus_power};
			ku_sy  <= {ku_sy[1:0], key_up};
			kd_sy  <= {kd_sy[1:0], key_down};
			if (pwr_sy[1] == pwr_sy[2]) pwr_ff <= pwr_sy[2];
			if (ku_sy[1] == ku_sy[2]) ku_ff <= ku_sy[2];
			if (kd_sy[1] == kd_sy[2]) kd_ff <= kd_sy[2];
		end
	end

	// 100 ms time base.
	logic [31:0] pre_ff;
	logic        tick;
	assign tick = (pre_ff == 32'(UNIT_CYC - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) pre_ff <= 32'h0000_0000;
		else if (ce) pre_ff <= tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
	end

	// Press length is counted in cycles, so a long press is strictly over the limit.
	localparam logic [31:0] LONG_CYC = 32'(LONG_PRESS_UNITS * UNIT_CYC);
	logic [31:0] held_ff;
	logic       key_dn_ff;
	logic       was_key_ff;
	logic       long_fire_ff;
	logic       key_any;
	logic       long_ev;
	logic       short_ev;
	assign key_any  = (ku_ff ^ kd_ff) & ctrl_ff[CTRL_KEYS] & pwr_ff;
	assign long_ev  = key_any & ~long_fire_ff & (held_ff == LONG_CYC);
	assign short_ev = ~key_any & was_key_ff & ~long_fire_ff & ctrl_ff[CTRL_KEYS];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_ff      <= 32'h0000_0000;
			key_dn_ff    <= 1'b0;
			was_key_ff   <= 1'b0;
			long_fire_ff <= 1'b0;
		end else if (ce) begin
			was_key_ff <= key_any;
			if (key_any) begin
				key_dn_ff <= kd_ff;
				if (held_ff != LONG_CYC) held_ff <= held_ff + 32'h0000_0001;
				if (long_ev) long_fire_ff <= 1'b1;
			end else begin
				held_ff      <= 32'h0000_0000;
				long_fire_ff <= 1'b0;
			end
		end
	end

	// Motor state machine.
	logic        dir_ff;
	logic        pend_dir_ff;
	logic        has_tgt_ff;
	logic [7:0]  tgt_ff;
	logic [15:0] units_ff;
	logic [31:0] acc_ff;
	logic        pwr_d_ff;
	logic        move_req;
	logic        move_dn;
	logic        stop_req;
	logic        step_req;
	logic        step_dn;
	logic        moving;
	logic [31:0] per_pct;
	assign moving = (state_ff != SMD_IDLE);
	// Cycles per one percent of travel; each travel second is ten units.
	assign per_pct = 32'(travel_s) * 32'(UNIT_CYC) / 32'd10;

	always_comb begin
		move_req = 1'b0;
		move_dn  = 1'b0;
		stop_req = 1'b0;
		step_req = 1'b0;
		step_dn  = 1'b0;
		if (cmd_wr && cmd_val[CMD_MOVE]) begin
			move_req = 1'b1;
			move_dn  = cmd_val[CMD_VAL] ^ inv;
		end
		if (cmd_wr && cmd_val[CMD_POS] && ctrl_ff[CTRL_POSEN]
			&& cmd_val[CMD_VAL +: 8] != pos_ff) begin
			move_req = 1'b1;
			move_dn  = cmd_val[CMD_VAL +: 8] > pos_ff;
		end
		if (cmd_wr && cmd_val[CMD_STOP]) stop_req = 1'b1;
		if (cmd_wr && cmd_val[CMD_STEP]) begin
			if (moving || !blind) stop_req = moving;
			else begin
				step_req = 1'b1;
				step_dn  = cmd_val[CMD_VAL] ^ inv;
			end
		end
		if (long_ev) begin
			move_req = 1'b1;
			move_dn  = key_dn_ff;
		end
		if (short_ev) begin
			if (moving) stop_req = 1'b1;
			else if (blind) begin
				step_req = 1'b1;
				step_dn  = key_dn_ff;
			end
		end
		if (pwr_ff && !pwr_d_ff && recov != SMD_RECOV_NONE) begin
			move_req = 1'b1;
			move_dn  = (recov == SMD_RECOV_DOWN);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff       <= SMD_IDLE;
			dir_ff         <= 1'b0;
			pend_dir_ff    <= 1'b0;
			has_tgt_ff     <= 1'b0;
			tgt_ff         <= 8'h00;
			units_ff       <= 16'h0000;
			acc_ff         <= 32'h0000_0000;
			pos_ff         <= 8'h00;
			pwr_d_ff       <= 1'b0;
			move_rpt_valid <= 1'b0;
			move_rpt_down  <= 1'b0;
			pos_rpt        <= '0;
		end else if (ce) begin
			pwr_d_ff       <= pwr_ff;
			move_rpt_valid <= 1'b0;
			pos_rpt.valid  <= 1'b0;
			if (!pwr_ff) begin
				state_ff <= SMD_IDLE;
			end else begin
				// Position estimate runs while a contact is energized.
				if (state_ff == SMD_RUN || state_ff == SMD_STEP) begin
					if (acc_ff + 32'd1 >= per_pct) begin
						acc_ff <= 32'h0000_0000;
						if (dir_ff && pos_ff < 8'(POS_FULL)) pos_ff <= pos_ff + 8'h01;
						if (!dir_ff && pos_ff != 8'h00) pos_ff <= pos_ff - 8'h01;
					end else acc_ff <= acc_ff + 32'd1;
				end
				if (tick && units_ff != 16'h0000) units_ff <= units_ff - 16'h0001;
				case (state_ff)
					SMD_IDLE: begin
						if (move_req) begin
							state_ff       <= SMD_RUN;
							dir_ff         <= move_dn;
							units_ff       <= 16'(travel_s * 16'd10 + 16'd1);
							has_tgt_ff     <= cmd_wr & cmd_val[CMD_POS];
							tgt_ff         <= cmd_val[CMD_VAL +: 8];
							move_rpt_valid <= 1'b1;
							move_rpt_down  <= move_dn;
						end else if (step_req) begin
							state_ff       <= SMD_STEP;
							dir_ff         <= step_dn;
							units_ff       <= 16'(step_n);
							has_tgt_ff     <= 1'b0;
							move_rpt_valid <= 1'b1;
							move_rpt_down  <= step_dn;
						end
					end
					SMD_RUN, SMD_STEP: begin
						if (stop_req || (move_req && move_dn != dir_ff)) begin
							state_ff    <= move_req ? SMD_DEAD : SMD_IDLE;
							pend_dir_ff <= move_dn;
							has_tgt_ff  <= cmd_wr & cmd_val[CMD_POS];
							tgt_ff      <= cmd_val[CMD_VAL +: 8];
							units_ff    <= 16'(dead_u) + 16'h0001;
							pos_rpt     <= '{valid: ctrl_ff[CTRL_FBEN], pos: pos_ff};
						end else if (units_ff == 16'h0000
							|| (has_tgt_ff && pos_ff == tgt_ff)) begin
							state_ff <= SMD_IDLE;
							pos_rpt  <= '{valid: ctrl_ff[CTRL_FBEN], pos: pos_ff};
						end else if (move_req) begin
							units_ff   <= 16'(travel_s * 16'd10 + 16'd1);
							has_tgt_ff <= cmd_wr & cmd_val[CMD_POS];
							tgt_ff     <= cmd_val[CMD_VAL +: 8];
						end
					end
					SMD_DEAD: begin
						if (stop_req) state_ff <= SMD_IDLE;
						else if (units_ff == 16'h0000) begin
							state_ff       <= SMD_RUN;
							dir_ff         <= pend_dir_ff;
							units_ff       <= 16'(travel_s * 16'd10 + 16'd1);
							move_rpt_valid <= 1'b1;
							move_rpt_down  <= pend_dir_ff;
						end
					end
					default: state_ff <= SMD_IDLE;
				endcase
			end
		end
	end

	// Contact outputs: only in run or step, never both, never without power.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relay     <= '0;
			led_night <= 1'b0;
			led_move  <= 1'b0;
		end else if (ce) begin
			relay.up   <= pwr_ff && (state_ff == SMD_RUN || state_ff == SMD_STEP) && !dir_ff;
			relay.down <= pwr_ff && (state_ff == SMD_RUN || state_ff == SMD_STEP) && dir_ff;
			led_night  <= pwr_ff && ctrl_ff[CTRL_NIGHT] && !moving;
			led_move   <= pwr_ff && moving;
		end
	end

	property p_no_power;
		@(posedge aclk) disable iff (!aresetn)
		!pwr_ff && ce |=> !relay.up && !relay.down;
	endproperty
	a_no_power: assert property (p_no_power) else $error("contact on without bus power");

	property p_night;
		@(posedge aclk) disable iff (!aresetn)
		led_night |-> !relay.up && !relay.down;
	endproperty
	a_night: assert property (p_night) else $error("night indicator lit while moving");

	property p_excl;
		@(posedge aclk) disable iff (!aresetn)
		!(relay.up && relay.down);
	endproperty
	a_excl: assert property (p_excl) else $error("both contacts energized");

	sequence s_rev;
		state_ff == SMD_DEAD ##1 state_ff == SMD_DEAD;
	endsequence
	property p_dead;
		@(posedge aclk) disable iff (!aresetn)
		s_rev |-> !relay.up && !relay.down;
	endproperty
	a_dead: assert property (p_dead) else $error("contact on during dead time");

	property p_report;
		@(posedge aclk) disable iff (!aresetn)
		ce && pwr_ff && state_ff == SMD_IDLE && move_req |=> move_rpt_valid && state_ff == SMD_RUN;
	endproperty
	a_report: assert property (p_report) else $error("no movement report at start");

	property p_keys;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_ff[CTRL_KEYS] |-> !long_ev && !short_ev && !key_any;
	endproperty
	a_keys: assert property (p_keys) else $error("key accepted while disabled");

	property p_pos_range;
		@(posedge aclk) disable iff (!aresetn)
		pos_ff <= 8'(POS_FULL);
	endproperty
	a_pos_range: assert property (p_pos_range) else $error("position above full");

	property p_fb;
		@(posedge aclk) disable iff (!aresetn)
		pos_rpt.valid |-> ctrl_ff[CTRL_FBEN] && $past(state_ff) != SMD_IDLE;
	endproperty
	a_fb: assert property (p_fb) else $error("position report out of place");

endmodule : smd_top

/* testbench.sv */
// Self-checking bench of the shutter motor control.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import smd_pkg::*;
	localparam int U = 20;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic bus_power, key_up, key_down, led_night, led_move, move_rpt_valid, move_rpt_down;
	logic ce;
	smd_relay_s relay;
	smd_pos_s pos_rpt;
	int miscompares = 0;
	int n_compared = 0;

	smd_top #(.UNIT_CYC(U)) smd_top_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .bus_power, .key_up, .key_down, .relay, .led_night, .led_move,
		.move_rpt_valid, .move_rpt_down, .pos_rpt);
	smd_partner smd_partner_inst (.aclk, .aresetn, .relay, .move_rpt_valid, .move_rpt_down,
		.pos_rpt);

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	task automatic tmo(input string nm);
		miscompares++;
		$display("[ERR] %s expected response seen timeout", nm);
		finish_test();
	endtask : tmo

	task automatic hold(input int n);
		repeat (n) @(posedge aclk);
	endtask : hold

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50 && !(aw_ok && w_ok); i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge aclk);
		if (s_axi_bvalid !== 1'b1) tmo("bvalid");
		`CHK("bresp", 2'h0, s_axi_bresp)
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (s_axi_rvalid !== 1'b1) tmo("rvalid");
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic cmd(input int b, input logic [7:0] v);
		axi_wr(REG_CMD, (32'h1 << b) | (32'(v) << CMD_VAL));
	endtask : cmd

	task automatic wait_rel(input logic [1:0] e, input int lim);
		int i;
		for (i = 0; i < lim && relay !== e; i++) @(posedge aclk);
		if (relay !== e) tmo("relay");
	endtask : wait_rel

	task automatic run_len(input logic [1:0] e, output int n);
		n = 0;
		while (relay === e && n < 400) begin
			@(posedge aclk);
			n++;
		end
	endtask : run_len

	task automatic t_regs;
		axi_rd(REG_CTRL);
		`CHK("ctrl_rst", CTRL_RST, rd)
		axi_rd(REG_TIMING);
		`CHK("timing_rst", TIMING_RST, rd)
		axi_rd(8'h10);
		`CHK("unmapped_resp", 2'h2, rr)
		axi_wr(REG_TIMING, 32'h0002_0202);
		axi_rd(REG_TIMING);
		`CHK("timing_wr", 32'h0002_0202, rd)
		$display("test regs done");
	endtask : t_regs

	task automatic t_pos;
		axi_wr(REG_CTRL, 32'h0000_0038);
		cmd(CMD_POS, 8'h32);
		wait_rel(2'b01, 20);
		wait_rel(2'b00, 400);
		hold(5);
		`CHK("pos_cnt", 1, smd_partner_inst.n_pos)
		`CHK("pos_val", 1'b1, smd_partner_inst.last_pos inside {[8'h31:8'h33]})
		axi_rd(REG_STATUS);
		`CHK("status_pos", 1'b1, rd[7:0] inside {[8'h31:8'h33]})
		axi_wr(REG_CTRL, 32'h0000_0018);
		cmd(CMD_POS, 8'h00);
		wait_rel(2'b10, 20);
		wait_rel(2'b00, 400);
		hold(5);
		`CHK("pos_cnt_off", 1, smd_partner_inst.n_pos)
		$display("test position done");
	endtask : t_pos

	task automatic t_travel;
		int n;
		logic ed;
		for (int k = 0; k < 4; k++) begin
			axi_wr(REG_CTRL, 32'h0000_000C | (k >> 1));
			hold(5);
			`CHK("night_idle", 1'b1, led_night)
			n = smd_partner_inst.n_move;
			ed = k[0] ^ k[1];
			cmd(CMD_MOVE, {7'h00, k[0]});
			wait_rel({~ed, ed}, 20);
			hold(2);
			`CHK("night_move", 1'b0, led_night)
			`CHK("led_move", 1'b1, led_move)
			`CHK("rpt_cnt", n + 1, smd_partner_inst.n_move)
			`CHK("rpt_dir", ed, smd_partner_inst.last_down)
			cmd(CMD_STOP, {7'h00, k[1]});
			wait_rel(2'b00, 20);
			`CHK("led_idle", 1'b0, led_move)
		end
		axi_wr(REG_CTRL, 32'h0000_0008);
		hold(5);
		`CHK("night_off", 1'b0, led_night)
		$display("test travel done");
	endtask : t_travel

	task automatic t_rev;
		int n;
		cmd(CMD_MOVE, 8'h01);
		wait_rel(2'b01, 20);
		hold(20);
		cmd(CMD_MOVE, 8'h00);
		wait_rel(2'b00, 10);
		run_len(2'b00, n);
		`CHK("rev_dir", 2'b10, relay)
		`CHK("dead_len", 1'b1, n >= 2 * U && n <= 3 * U + 10)
		cmd(CMD_STOP, 8'h00);
		wait_rel(2'b00, 20);
		$display("test reversal done");
	endtask : t_rev

	task automatic t_ce;
		cmd(CMD_MOVE, 8'h01);
		wait_rel(2'b01, 20);
		cmd(CMD_MOVE, 8'h00);
		wait_rel(2'b00, 10);
		ce <= 1'b0;
		hold(4 * U);
		`CHK("ce_frozen", 2'b00, relay)
		ce <= 1'b1;
		wait_rel(2'b10, 4 * U);
		cmd(CMD_STOP, 8'h00);
		wait_rel(2'b00, 20);
		$display("test clock enable done");
	endtask : t_ce

	task automatic t_step;
		int n;
		logic ed;
		for (int k = 0; k < 4; k++) begin
			axi_wr(REG_CTRL, 32'h0000_000A | (k >> 1));
			ed = k[0] ^ k[1];
			cmd(CMD_STEP, {7'h00, k[0]});
			wait_rel({~ed, ed}, 20);
			run_len({~ed, ed}, n);
			`CHK("step_len", 1'b1, n >= U && n <= 2 * U + 4)
			`CHK("step_end", 2'b00, relay)
		end
		$display("test step done");
	endtask : t_step

	task automatic t_keys;
		logic bad;
		bad = 1'b0;
		axi_wr(REG_CTRL, 32'h0000_0002);
		key_down <= 1'b1;
		for (int i = 0; i < 150; i++) begin
			@(posedge aclk);
			if (relay !== 2'b00) bad = 1'b1;
		end
		key_down <= 1'b0;
		`CHK("keys_off", 1'b0, bad)
		axi_wr(REG_CTRL, 32'h0000_0008);
		key_up <= 1'b1;
		hold(40);
		key_up <= 1'b0;
		hold(40);
		`CHK("short_idle", 2'b00, relay)
		key_down <= 1'b1;
		wait_rel(2'b01, 160);
		key_down <= 1'b0;
		hold(40);
		`CHK("long_keeps", 2'b01, relay)
		key_up <= 1'b1;
		wait_rel(2'b00, 160);
		wait_rel(2'b10, 200);
		key_up <= 1'b0;
		hold(20);
		key_down <= 1'b1;
		hold(40);
		key_down <= 1'b0;
		wait_rel(2'b00, 40);
		axi_wr(REG_CTRL, 32'h0000_000A);
		key_up <= 1'b1;
		hold(40);
		key_up <= 1'b0;
		wait_rel(2'b10, 60);
		wait_rel(2'b00, 100);
		$display("test keys done");
	endtask : t_keys

	task automatic t_power;
		logic [1:0] e;
		for (int r = 0; r < 3; r++) begin
			axi_wr(REG_CTRL, 32'h0000_0008 | (r << CTRL_RECOV_LO));
			cmd(CMD_MOVE, 8'h01);
			wait_rel(2'b01, 20);
			bus_power <= 1'b0;
			wait_rel(2'b00, 20);
			cmd(CMD_MOVE, 8'h01);
			hold(20);
			`CHK("no_power", 2'b00, relay)
			bus_power <= 1'b1;
			e = (r == 1) ? 2'b10 : (r == 2) ? 2'b01 : 2'b00;
			hold(30);
			`CHK("recovery", e, relay)
			cmd(CMD_MOVE, 8'h00);
			hold(5);
			cmd(CMD_STOP, 8'h00);
			wait_rel(2'b00, 20);
		end
		`CHK("interlock", 0, smd_partner_inst.n_both)
		$display("test power done");
	endtask : t_power

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, key_up, key_down, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		bus_power = 1'b1;
		ce = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_pos();
		t_travel();
		t_rev();
		t_ce();
		t_step();
		t_keys();
		t_power();
		finish_test();
	end
endmodule : testbench
